// File: logic/caf_pkg.sv
// Purpose: constants and types for the channel action flag transfer block
// Assumes: one clock, synchronous active-high reset, APB register access
// Notes: command word holds word count in the top field, address below
//
// Contract
// - command word register drives the physical address for channel cache cycles.
// - after request setup, hold until cache grants a channel cycle.
// - buffer-to-memory moves words singly, one load pulse each, starting write with the first word.
// - each moved word invalidates cache, decrements counter, advances pointer and select.
// - counter at zero raises the second control RAM request.
// - second RAM cycle only when no bus data or control request pends.
// - second cycle writes pointer plus action count back to control RAM.
// - second cycle subtracts count from word count, adds to address, writes back.
// - after second RAM cycle, clear request-in-progress.
// - zero fill skips cache cycle, requests second RAM cycle right away.
// - read-reverse loads memory buffers in reverse order.
// - read-reverse subtracts the action count from the address.
// - read-reverse withholds memory write start until all words are loaded.
// - queue request when arithmetic reports enough empty buffer locations.
// - start up to four words after previous request, no fetch pending.
// - grant puts channel number in address bits 0-2, starts RAM request.
// - command word buffer address bit 3 is zero at grant.
// - RAM cycle waits out bus requests, sets channel request, forms bits 3-6.
// - phase T2 loads request counter and buffer memory pointer.
// - memory-to-buffer words decrement counter and advance pointer.
// - phase T3 raises channel request and sets word request mask.
// - phase T1 loads select from address low bits; increments per word.
// - on word ready and no bus data request, move word and step counters.

package caf_pkg;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [11:0] CAF_CTRL_OFF = 12'h000;
	localparam logic [11:0] CAF_STAT_OFF = 12'h004;
	localparam logic [11:0] CAF_DONE_OFF = 12'h008;
	localparam int CAF_CTRL_EN_BIT = 0;
	localparam int CAF_CTRL_DIR_BIT = 1;
	localparam int CAF_CTRL_ZERO_BIT = 2;
	localparam int CAF_CTRL_REV_BIT = 3;
	localparam logic [3:0] CAF_CTRL_RST = 4'h0;

	// ***************************************************************
	// command word layout and widths
	// ***************************************************************
	localparam int CAF_CW_W = 36;
	localparam int CAF_ADR_W = 22;
	localparam int CAF_WC_W = 14;
	localparam int CAF_CNT_W = 3;
	localparam int CAF_PTR_W = 4;
	localparam logic [2:0] CAF_MAX_WORDS = 3'h4;

	// gray codes along the usual path from IDLE to RAM2; the step back to IDLE flips all three bits
	typedef enum logic [2:0]
	{
		CAF_IDLE = 3'h0,
		CAF_GRANT = 3'h1,
		CAF_RAM1 = 3'h3,
		CAF_WAITC = 3'h2,
		CAF_MOVE = 3'h6,
		CAF_RAM2 = 3'h7
	} caf_state_e;

endpackage

// File: logic/caf_transfer.sv
// Purpose: action flag request sequencing between channel buffer and memory buffers
// Assumes: partner signals synchronous to mclk; APB slave with one wait state
// Notes: phases T0-T3 of the RAM cycle all complete in one clock
`timescale 1ns/1ps
`default_nettype none

module caf_transfer
	import caf_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic actionFlagQueueEnable, // enough words or room queued
	input wire logic commandWordFetch, // fetch request pending
	input wire logic [2:0] channelNum, // highest priority channel
	input wire logic [CAF_CNT_W-1:0] actionCount, // words this request
	input wire logic [CAF_PTR_W-1:0] memPointer, // start location in buffer
	input wire logic [CAF_CW_W-1:0] commandWordIn, // read data of command buffer
	input wire logic busDataRequest, // higher priority bus data
	input wire logic busControlRequest, // higher priority bus control
	input wire logic cacheChannelCycle, // cache grants channel cycle
	input wire logic wordReadyFlag, // requested word in memory buffer
	output logic actionFlagGrant, // grant pulse
	output logic bufferRequestInProgress, // request in progress
	output logic [3:0] commandBufferAddr, // command word buffer address
	output logic [6:0] channelBufferAddr, // channel word buffer address
	output logic [CAF_ADR_W-1:0] physicalAddress, // address for cache cycle
	output logic channelRequest, // channel request to cache
	output logic [3:0] wordRequestMask, // words requested
	output logic [1:0] bufferSelect, // memory buffer of current word
	output logic bufferLoadPulse, // load memory buffer from channel buffer
	output logic cacheInvalidate, // invalidate matching cache word
	output logic memoryWriteStart, // start memory write
	output logic counterStepEnable, // counters stepped
	output logic channelBufferWrite, // write word to channel buffer
	output logic ramWrite, // control RAM write
	output logic [CAF_PTR_W-1:0] ramWriteData, // updated pointer
	output logic commandBufferWrite, // command word buffer write
	output logic [CAF_CW_W-1:0] commandBufferData // updated command word
);

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed
	{
		caf_state_e st;
		logic bri;
		logic grant;
		logic [3:0] cwbAddr;
		logic [6:0] chbAddr;
		logic [CAF_CW_W-1:0] channel_command_word;
		logic [1:0] bsel;
		logic [1:0] moveSel;
		logic [CAF_CNT_W-1:0] reqCtr;
		logic [CAF_CNT_W-1:0] cnt;
		logic [CAF_PTR_W-1:0] ptr;
		logic [CAF_PTR_W-1:0] ptrStart;
		logic chanReq;
		logic [3:0] mask;
		logic started;
		logic loadPulse;
		logic inval;
		logic memStart;
		logic stepEn;
		logic chbWrite;
		logic ramWr;
		logic [CAF_PTR_W-1:0] ramData;
		logic cwbWrite;
		logic [CAF_CW_W-1:0] cwbData;
		logic [3:0] ctrl;
		logic [15:0] doneCount;
		logic ready;
		logic [31:0] rdata;
		logic err;
	} caf_regs_s;

	caf_regs_s q;
	caf_regs_s next_q;
	logic busFree;
	logic dirOut;
	logic reverse;
	logic [1:0] adrLow;

	// word request mask from low address bits and count
	function automatic logic [3:0] cafMask(input logic [1:0] lo, input logic [CAF_CNT_W-1:0] n);
		logic [3:0] m;
		logic [3:0] top;
		m = 4'h0;
		top = {2'h0, lo} + {1'h0, n};
		for (int i = 0; i < 4; i++)
		begin
			m[i] = (4'(i) >= {2'h0, lo}) && (4'(i) < top);
		end
		return m;
	endfunction

	// apb read mux, used for read data only; error decode compares the offsets itself
	function automatic logic [31:0] cafRead(input logic [11:0] a, input caf_regs_s s);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			CAF_CTRL_OFF: r = {28'h0, s.ctrl};
			CAF_STAT_OFF: r = {12'h0, s.bsel, s.ptr, 1'h0, s.reqCtr, s.chanReq, s.bri, 5'h0, s.st};
			CAF_DONE_OFF: r = {16'h0, s.doneCount};
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	assign busFree = !busDataRequest && !busControlRequest;
	assign dirOut = q.ctrl[CAF_CTRL_DIR_BIT];
	assign reverse = dirOut && q.ctrl[CAF_CTRL_REV_BIT];
	assign adrLow = q.channel_command_word[1:0];

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb
	begin
		next_q = q;
		next_q.grant = 1'b0;
		next_q.loadPulse = 1'b0;
		next_q.inval = 1'b0;
		next_q.memStart = 1'b0;
		next_q.stepEn = 1'b0;
		next_q.chbWrite = 1'b0;
		next_q.ramWr = 1'b0;
		next_q.cwbWrite = 1'b0;
		next_q.ready = 1'b0;
		next_q.err = 1'b0;
		case (q.st)
			CAF_IDLE:
			begin
				// only one request at a time; fetch requests outrank us
				if (q.ctrl[CAF_CTRL_EN_BIT] && actionFlagQueueEnable && !commandWordFetch)
				begin
					next_q.grant = 1'b1;
					next_q.bri = 1'b1;
					next_q.cwbAddr = {1'b0, channelNum};
					next_q.chbAddr = {4'h0, channelNum};
					next_q.st = CAF_GRANT;
				end
			end
			CAF_GRANT:
			begin
				// buffer read data lands one cycle after the address
				next_q.channel_command_word = commandWordIn;
				next_q.st = CAF_RAM1;
			end
			CAF_RAM1:
			begin
				if (busFree)
				begin
					// T1: select from low address bits, last word first when reversed
					next_q.bsel = reverse ? 2'(adrLow + actionCount - 3'h1) : adrLow;
					// T2: counter and pointer
					next_q.reqCtr = actionCount;
					next_q.cnt = actionCount;
					next_q.ptr = memPointer;
					next_q.ptrStart = memPointer;
					next_q.chbAddr = {memPointer, q.chbAddr[2:0]};
					next_q.mask = cafMask(adrLow, actionCount);
					next_q.started = 1'b0;
					if (dirOut && q.ctrl[CAF_CTRL_ZERO_BIT])
					begin
						// zero fill: buffered words are dropped unread
						next_q.st = CAF_RAM2;
					end
					else
					begin
						next_q.chanReq = 1'b1;
						next_q.st = CAF_WAITC;
					end
				end
			end
			CAF_WAITC:
			begin
				if (cacheChannelCycle)
				begin
					next_q.chanReq = 1'b0;
					next_q.st = CAF_MOVE;
				end
			end
			CAF_MOVE:
			begin
				if (q.reqCtr == 3'h0)
				begin
					next_q.st = CAF_RAM2;
				end
				else if (dirOut)
				begin
					// one word per clock toward the memory buffers
					next_q.loadPulse = 1'b1;
					next_q.inval = 1'b1;
					next_q.stepEn = 1'b1;
					next_q.moveSel = q.bsel;
					next_q.chbAddr = {q.ptr, q.chbAddr[2:0]};
					next_q.reqCtr = q.reqCtr - 3'h1;
					next_q.ptr = q.ptr + 4'h1;
					next_q.bsel = reverse ? q.bsel - 2'h1 : q.bsel + 2'h1;
					if (!reverse && !q.started)
					begin
						next_q.memStart = 1'b1;
						next_q.started = 1'b1;
					end
					if (reverse && q.reqCtr == 3'h1)
					begin
						next_q.memStart = 1'b1;
					end
				end
				else if (wordReadyFlag && !busDataRequest)
				begin
					next_q.chbWrite = 1'b1;
					next_q.stepEn = 1'b1;
					next_q.moveSel = q.bsel;
					next_q.chbAddr = {q.ptr, q.chbAddr[2:0]};
					next_q.reqCtr = q.reqCtr - 3'h1;
					next_q.ptr = q.ptr + 4'h1;
					next_q.bsel = q.bsel + 2'h1;
				end
			end
			CAF_RAM2:
			begin
				if (busFree)
				begin
					next_q.ramWr = 1'b1;
					next_q.ramData = q.ptrStart + {1'b0, q.cnt};
					next_q.cwbWrite = 1'b1;
					next_q.cwbAddr = {1'b0, q.cwbAddr[2:0]};
					next_q.cwbData[CAF_CW_W-1:CAF_ADR_W] = q.channel_command_word[CAF_CW_W-1:CAF_ADR_W]
						- {{(CAF_WC_W-CAF_CNT_W){1'b0}}, q.cnt};
					if (reverse)
					begin
						next_q.cwbData[CAF_ADR_W-1:0] = q.channel_command_word[CAF_ADR_W-1:0]
							- {{(CAF_ADR_W-CAF_CNT_W){1'b0}}, q.cnt};
					end
					else
					begin
						next_q.cwbData[CAF_ADR_W-1:0] = q.channel_command_word[CAF_ADR_W-1:0]
							+ {{(CAF_ADR_W-CAF_CNT_W){1'b0}}, q.cnt};
					end
					next_q.bri = 1'b0;
					next_q.doneCount = q.doneCount + 16'h1;
					next_q.st = CAF_IDLE;
				end
			end
			default:
			begin
				next_q.st = CAF_IDLE;
			end
		endcase
		// ***************************************************************
		// apb slave: one wait state, write commits at completion edge
		// ***************************************************************
		if (psel && penable && !q.ready)
		begin
			next_q.ready = 1'b1;
			next_q.rdata = cafRead(paddr, q);
			next_q.err = !(paddr == CAF_CTRL_OFF || paddr == CAF_STAT_OFF || paddr == CAF_DONE_OFF);
		end
		if (psel && penable && q.ready && pwrite && paddr == CAF_CTRL_OFF)
		begin
			next_q.ctrl = pwdata[3:0];
		end
	end

	// state register
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

	// outputs straight from flops
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign actionFlagGrant = q.grant;
	assign bufferRequestInProgress = q.bri;
	assign commandBufferAddr = q.cwbAddr;
	assign channelBufferAddr = q.chbAddr;
	assign physicalAddress = q.channel_command_word[CAF_ADR_W-1:0];
	assign channelRequest = q.chanReq;
	assign wordRequestMask = q.mask;
	assign bufferSelect = q.moveSel;
	assign bufferLoadPulse = q.loadPulse;
	assign cacheInvalidate = q.inval;
	assign memoryWriteStart = q.memStart;
	assign counterStepEnable = q.stepEn;
	assign channelBufferWrite = q.chbWrite;
	assign ramWrite = q.ramWr;
	assign ramWriteData = q.ramData;
	assign commandBufferWrite = q.cwbWrite;
	assign commandBufferData = q.cwbData;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cafClk @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_GRANT_COND: assert property (q.grant |-> $past(actionFlagQueueEnable) && !$past(commandWordFetch))
		else $error("grant without queue or with fetch pending");
	AST_GRANT_ADDR: assert property (q.grant |-> q.cwbAddr == {1'b0, $past(channelNum)})
		else $error("grant address wrong");
	AST_RAM1_WAIT: assert property ((q.st == CAF_RAM1 && !busFree) |=> q.st == CAF_RAM1)
		else $error("ram cycle taken over bus request");
	AST_HOLD_CSH: assert property ((q.st == CAF_WAITC && !cacheChannelCycle) |=> q.st == CAF_WAITC && !q.stepEn)
		else $error("moved without cache channel cycle");
	AST_LOAD_STEP: assert property (q.loadPulse |-> q.stepEn && q.inval && q.reqCtr == $past(q.reqCtr) - 3'h1)
		else $error("load pulse without counter step");
	AST_RAM2_DONE: assert property (q.ramWr |-> q.cwbWrite && !q.bri && q.st == CAF_IDLE)
		else $error("second ram cycle did not end request");
	AST_REV_START: assert property ((q.memStart && reverse) |-> q.reqCtr == 3'h0)
		else $error("reverse write started early");
	AST_ZERO_SKIP: assert property ((q.st == CAF_RAM1 && busFree && dirOut && q.ctrl[CAF_CTRL_ZERO_BIT])
		|=> q.st == CAF_RAM2 && !q.chanReq)
		else $error("zero fill requested cache cycle");
	AST_APB_READY: assert property ((psel && penable && !q.ready) |=> q.ready)
		else $error("apb access not answered");

endmodule

`default_nettype wire

// File: bench/caf_cache_model.sv
// Purpose: cache and core control stand-in for channel cycles
// Assumes: channel request is a level held until the grant is seen
// Notes: slow sets both the grant delay and the core read delay
`timescale 1ns/1ps
`default_nettype none

module caf_cache_model
(
	input wire logic mclk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic channelRequest, // request from channel control
	input wire logic bufferRequestInProgress, // request still open
	input wire logic [3:0] slow, // answer delay in cycles
	output logic cacheChannelCycle, // channel cycle grant pulse
	output logic wordReadyFlag // words sit in memory buffers
);
	// ***************************************************************
	// grant and word ready
	// ***************************************************************
	logic [3:0] waitCnt;
	logic served;

	// one grant per request; ready holds until the request closes
	always_ff @(posedge mclk)
	begin
		cacheChannelCycle <= 1'b0;
		if (sys_rst || !bufferRequestInProgress)
		begin
			waitCnt <= 4'h0;
			served <= 1'b0;
			wordReadyFlag <= 1'b0;
		end
		else if (channelRequest && !served)
		begin
			waitCnt <= waitCnt + 4'h1;
			if (waitCnt >= slow)
			begin
				cacheChannelCycle <= 1'b1;
				served <= 1'b1;
				waitCnt <= 4'h0;
			end
		end
		else if (served)
		begin
			waitCnt <= waitCnt + 4'h1;
			wordReadyFlag <= wordReadyFlag || (waitCnt >= slow);
		end
	end
endmodule
`default_nettype wire

// File: bench/caf_transfer_tb.sv
// Purpose: self-checking bench for the action flag transfer block
// Assumes: cache model answers channel requests after slow cycles
// Notes: the four transfer scenarios each run one request and check what came back
`timescale 1ns/1ps
`default_nettype none

module caf_transfer_tb
	import caf_pkg::*;
;
	logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic actionFlagQueueEnable, commandWordFetch, busDataRequest, busControlRequest;
	logic [2:0] channelNum, actionCount;
	logic [3:0] memPointer, commandBufferAddr, wordRequestMask, ramWriteData, slow, ramD, maskAt;
	logic [CAF_CW_W-1:0] commandWordIn, commandBufferData, cmdD;
	logic cacheChannelCycle, wordReadyFlag, actionFlagGrant, bufferRequestInProgress;
	logic channelRequest, bufferLoadPulse, cacheInvalidate, memoryWriteStart;
	logic counterStepEnable, channelBufferWrite, ramWrite, commandBufferWrite;
	logic [6:0] channelBufferAddr;
	logic [CAF_ADR_W-1:0] physicalAddress;
	logic [1:0] bufferSelect;
	logic [7:0] selSeq;
	int miscompares, checkCount, nLoad, nWr, nStep, nInv, nReq, viol, startAt, bLo, bHi, cHi, fHi;

	// ***************************************************************
	// clock, design and partner
	// ***************************************************************
	always #5 mclk = ~mclk;

	caf_transfer dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .actionFlagQueueEnable, .commandWordFetch, .channelNum, .actionCount,
		.memPointer, .commandWordIn, .busDataRequest, .busControlRequest, .cacheChannelCycle,
		.wordReadyFlag, .actionFlagGrant, .bufferRequestInProgress, .commandBufferAddr,
		.channelBufferAddr, .physicalAddress, .channelRequest, .wordRequestMask, .bufferSelect,
		.bufferLoadPulse, .cacheInvalidate, .memoryWriteStart, .counterStepEnable,
		.channelBufferWrite, .ramWrite, .ramWriteData, .commandBufferWrite, .commandBufferData);

	caf_cache_model cache (.mclk, .sys_rst, .channelRequest, .bufferRequestInProgress, .slow,
		.cacheChannelCycle, .wordReadyFlag);

	// ***************************************************************
	// shared tasks
	// ***************************************************************
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_val(input logic [35:0] got, input logic [35:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// apb transfer; request held until pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask

	// one request, watched at falling edges until the pointer write-back
	task automatic run(input logic [3:0] ctrl, input logic [2:0] ch, cnt, input logic [3:0] ptr,
		input logic [35:0] cw);
		logic [31:0] rd;
		logic e, bAt, cAt, fAt, seenCc, prevReq, done;
		int i;
		apb(1'b1, CAF_CTRL_OFF, {28'h0, ctrl}, rd, e);
		nLoad = 0;
		nWr = 0;
		nStep = 0;
		nInv = 0;
		nReq = 0;
		viol = 0;
		startAt = 7;
		selSeq = 8'h00;
		seenCc = 1'b0;
		prevReq = 1'b0;
		done = 1'b0;
		i = 0;
		channelNum <= ch;
		actionCount <= cnt;
		memPointer <= ptr;
		commandWordIn <= cw;
		actionFlagQueueEnable <= 1'b1;
		commandWordFetch <= (fHi > 0);
		busControlRequest <= (cHi > 0);
		while (!done && i < 300)
		begin
			@(posedge mclk);
			bAt = busDataRequest;
			cAt = busControlRequest;
			fAt = commandWordFetch;
			seenCc = seenCc | cacheChannelCycle;
			if (actionFlagGrant)
				actionFlagQueueEnable <= 1'b0;
			busDataRequest <= (i >= bLo && i < bHi);
			busControlRequest <= (i < cHi);
			commandWordFetch <= (i < fHi);
			@(negedge mclk);
			if (actionFlagGrant)
				chk_val({commandBufferAddr, channelBufferAddr[2:0]}, {1'b0, ch, ch});
			if (actionFlagGrant && fAt)
				viol++;
			if (channelRequest && !prevReq)
			begin
				nReq++;
				maskAt = wordRequestMask;
				if (cAt)
					viol++;
			end
			if (channelRequest)
				chk_val(physicalAddress, cw[21:0]);
			prevReq = channelRequest;
			if (bufferLoadPulse && !seenCc)
				viol++;
			if (bufferLoadPulse && memoryWriteStart)
				startAt = nLoad;
			if (channelBufferWrite && bAt)
				viol++;
			if (bufferLoadPulse || channelBufferWrite)
				chk_val(channelBufferAddr, {4'(ptr + nLoad + nWr), ch});
			if (bufferLoadPulse || channelBufferWrite)
				selSeq = {selSeq[5:0], bufferSelect};
			nLoad += bufferLoadPulse;
			nWr += channelBufferWrite;
			nStep += counterStepEnable;
			nInv += cacheInvalidate;
			if (ramWrite)
			begin
				if (bAt || cAt)
					viol++;
				ramD = ramWriteData;
				cmdD = commandBufferData;
				done = 1'b1;
				chk_val({commandBufferWrite, commandBufferAddr}, {1'b1, 1'b0, ch});
				chk_val(bufferRequestInProgress, 1'b0);
			end
			i++;
		end
		if (!done)
		begin
			miscompares++;
			report_and_stop();
		end
		chk_val(viol, 0);
		bLo = 0;
		bHi = 0;
		cHi = 0;
		fHi = 0;
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		chk_val({actionFlagGrant, bufferRequestInProgress, channelRequest, ramWrite}, 0);
		apb(1'b0, CAF_CTRL_OFF, 32'h0, d, e);
		chk_val({e, d}, 0);
		apb(1'b1, CAF_DONE_OFF, 32'h0000_00FF, d, e);
		apb(1'b0, CAF_DONE_OFF, 32'h0, d, e);
		chk_val({e, d}, 0);
		apb(1'b0, 12'h00C, 32'h0, d, e);
		chk_val({e, d}, 33'h1_0000_0000);
		$display("test regs done");
	endtask

	// forward, pointer wraps, control request stalls the first cycle
	task automatic t_out();
		slow <= 4'h3;
		cHi = 6;
		run(4'h3, 3'h5, 3'h2, 4'hE, {14'h0064, 22'h000101});
		chk_val(nLoad, 2);
		chk_val(startAt, 0);
		chk_val(nInv, 2);
		chk_val(nStep, 2);
		chk_val(selSeq, 8'h06);
		chk_val(maskAt, 4'h6);
		chk_val(ramD, 4'h0);
		chk_val(cmdD, {14'h0062, 22'h000103});
		$display("test out done");
	endtask

	task automatic t_rev();
		slow <= 4'h1;
		run(4'hB, 3'h2, 3'h3, 4'h1, {14'h000A, 22'h000202});
		chk_val(nLoad, 3);
		chk_val(startAt, 2);
		chk_val(selSeq, 8'h0E);
		chk_val(ramD, 4'h4);
		chk_val(cmdD, {14'h0007, 22'h0001FF});
		$display("test reverse done");
	endtask

	task automatic t_zero();
		run(4'h7, 3'h0, 3'h4, 4'h2, {14'h0020, 22'h000010});
		chk_val(nReq, 0);
		chk_val(nLoad, 0);
		chk_val(ramD, 4'h6);
		chk_val(cmdD, {14'h001C, 22'h000014});
		$display("test zero fill done");
	endtask

	// inbound, fetch pending at start, data bus stalls the moves
	task automatic t_in();
		slow <= 4'h2;
		bLo = 12;
		bHi = 20;
		fHi = 5;
		run(4'h1, 3'h7, 3'h4, 4'h3, {14'h0004, 22'h3FFFFC});
		chk_val(nReq, 1);
		chk_val(maskAt, 4'hF);
		chk_val(nWr, 4);
		chk_val(nStep, 4);
		chk_val(selSeq, 8'h1B);
		chk_val(ramD, 4'h7);
		chk_val(cmdD, {14'h0000, 22'h000000});
		$display("test in done");
	endtask

	task automatic t_done();
		logic [31:0] d;
		logic e;
		apb(1'b0, CAF_DONE_OFF, 32'h0, d, e);
		chk_val({e, d}, 4);
		$display("test count done");
	endtask

	// reset, then every scenario in turn
	initial
	begin
		{mclk, psel, penable, pwrite, paddr, pwdata} = '0;
		{actionFlagQueueEnable, commandWordFetch, busDataRequest, busControlRequest} = '0;
		{channelNum, actionCount, memPointer, commandWordIn, slow} = '0;
		{miscompares, checkCount, bLo, bHi, cHi, fHi} = '0;
		sys_rst = 1'b1;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_out();
		t_rev();
		t_zero();
		t_in();
		t_done();
		report_and_stop();
	end
endmodule
`default_nettype wire
